// *** core/scg_pkg.sv ***
//
// Behaviour
// - Main clock runs from system RC oscillator until software writes source field.
// - Main clock feeds 8-bit prescaler; all clocks undivided after reset.
// - Divide enable set: clock is main divided by two to select plus one.
// - Hardware raises peripheral division when it would outrun the CPU.
// - High speed bus clock always uses the CPU division.
// - High speed bus select writes ignored; reads return CPU select.
// - Settled bit reads zero after select write until applied, then one.
// - Settled rise sets interrupt status; mask bit forwards it as request.
// - Writing one to enable register sets matching mask bit.
// - Module clocks enabled at reset; mask bit zero gates, one enables.
// - Masked module stops and its registers are unreachable.
// - Module on several domains has one mask bit per domain.
// - Own bus clock on at reset; once off, only reset restores.
// - Sleep request carries mode index; matching domains stop.
// - Sleep halts CPU and stopped domains whatever the masks.
// - Interrupt ends sleep and restarts CPU and halted modules.
// - Interrupt from an unclocked source may never wake the device.
// - Index 0 CPU, 1 adds bus, 2 adds peripherals, 3-5 sources.
package scg_pkg;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam int NPB = 2;
    localparam logic [7:0] OFS_MAIN = 8'h00;
    localparam logic [7:0] OFS_CPU_CLOCK_SELECT = 8'h04;
    localparam logic [7:0] OFS_HIGH_SPEED_BUS_CLOCK_SELECT = 8'h08;
    localparam logic [7:0] OFS_PBSEL0 = 8'h0C;
    localparam logic [7:0] OFS_CPU_CLOCK_MASK = 8'h20;
    localparam logic [7:0] OFS_HIGH_SPEED_BUS_CLOCK_MASK = 8'h24;
    localparam logic [7:0] OFS_PBMASK0 = 8'h28;
    localparam logic [7:0] OFS_IER = 8'h40;
    localparam logic [7:0] OFS_IDR = 8'h44;
    localparam logic [7:0] OFS_IMR = 8'h48;
    localparam logic [7:0] OFS_ISR = 8'h4C;
    localparam logic [7:0] OFS_ICR = 8'h50;
    localparam logic [7:0] OFS_SR = 8'h54;
    localparam int DIV_BIT = 7;
    localparam int PM_MASK_BIT = 0;
    localparam logic [2:0] SRC_SYSTEM_RC_OSCILLATOR = 3'h0;
    localparam logic [31:0] MASK_RST = 32'hFFFFFFFF;
    localparam logic [7:0] CNT_WRAP = 8'hFF;
    localparam logic [2:0] SLP_HSB = 3'h1;
    localparam logic [2:0] SLP_PB = 3'h2;
    localparam logic [2:0] SLP_SRC = 3'h3;
    localparam logic [2:0] SLP_MAX = 3'h5;

    typedef struct packed {
        logic div;
        logic [2:0] sel;
    } scg_div_s;

    typedef struct packed {
        logic ap_act;
        logic ap_wr;
        logic [7:0] ap_addr;
        logic rd_wait;
        logic [31:0] rdata;
        logic [2:0] src;
        scg_div_s cpu;
        scg_div_s [NPB-1:0] pb;
        scg_div_s a_cpu;
        scg_div_s [NPB-1:0] a_pb;
        logic ready;
        logic interrupt_status_register;
        logic interrupt_mask_register;
        logic [31:0] cpu_mask;
        logic [31:0] hsb_mask;
        logic [NPB-1:0][31:0] pb_mask;
        logic sleeping;
        logic [2:0] slp_idx;
        logic [7:0] cnt;
    } scg_state_s;

endpackage : scg_pkg

// *** core/scg_clock_gen.sv ***
`timescale 1ns/1ps
module scg_clock_gen
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic sleep_req,
    input wire logic [2:0] sleep_idx,
    input wire logic wake_irq,
    output logic [2:0] main_clock_source_field,
    output logic cpu_ce,
    output logic hsb_ce,
    output logic [scg_pkg::NPB-1:0] pb_ce,
    output logic [31:0] cpu_clk_en,
    output logic [31:0] hsb_clk_en,
    output logic [scg_pkg::NPB-1:0][31:0] pb_clk_en,
    output logic gclk_run,
    output logic src_run,
    output logic irq
);

    scg_pkg::scg_state_s s_q;
    scg_pkg::scg_state_s s_d;
    logic pm_ok;
    logic cpu_run;
    logic hsb_run;
    logic pb_run;
    logic cpu_tick;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Division exponent: zero means undivided
    function automatic logic [3:0] expo(input scg_pkg::scg_div_s d);
        expo = d.div ? ({1'b0, d.sel} + 4'h1) : 4'h0;
    endfunction : expo

    // Tick when the low prescaler bits are all ones
    function automatic logic tick(input scg_pkg::scg_div_s d,
                                  input logic [7:0] cnt);
        logic [7:0] low;
        low = 8'((9'h002 << d.sel) - 9'h001);
        tick = !d.div || ((cnt | ~low) == scg_pkg::CNT_WRAP);
    endfunction : tick

    // Peripheral never faster than CPU
    function automatic scg_pkg::scg_div_s fix(input scg_pkg::scg_div_s p,
                                              input scg_pkg::scg_div_s c);
        fix = (expo(p) < expo(c)) ? c : p;
    endfunction : fix

    function automatic logic [31:0] rd(input scg_pkg::scg_state_s s,
                                       input logic [7:0] a);
        rd = 32'h00000000;
        if (a == scg_pkg::OFS_MAIN)
            rd = {29'h0, s.src};
        // Bus select mirrors CPU select
        if (a == scg_pkg::OFS_CPU_CLOCK_SELECT || a == scg_pkg::OFS_HIGH_SPEED_BUS_CLOCK_SELECT)
            rd = {24'h0, s.cpu.div, 4'h0, s.cpu.sel};
        if (a == scg_pkg::OFS_CPU_CLOCK_MASK)
            rd = s.cpu_mask;
        if (a == scg_pkg::OFS_HIGH_SPEED_BUS_CLOCK_MASK)
            rd = s.hsb_mask;
        for (int i = 0; i < scg_pkg::NPB; i++)
        begin
            if (a == scg_pkg::OFS_PBSEL0 + 8'(4 * i))
                rd = {24'h0, s.pb[i].div, 4'h0, s.pb[i].sel};
            if (a == scg_pkg::OFS_PBMASK0 + 8'(4 * i))
                rd = s.pb_mask[i];
        end
        if (a == scg_pkg::OFS_IMR)
            rd = {31'h0, s.interrupt_mask_register};
        if (a == scg_pkg::OFS_ISR)
            rd = {31'h0, s.interrupt_status_register};
        if (a == scg_pkg::OFS_SR)
            rd = {31'h0, s.ready};
    endfunction : rd

    // ------------------------------------------------------------
    // Clock enables and gating
    // ------------------------------------------------------------
    // Domains stopped by sleep index
    always_comb
    begin
        cpu_run = !s_q.sleeping;
        hsb_run = !(s_q.sleeping && s_q.slp_idx >= scg_pkg::SLP_HSB);
        pb_run = !(s_q.sleeping && s_q.slp_idx >= scg_pkg::SLP_PB);
        src_run = !(s_q.sleeping && s_q.slp_idx >= scg_pkg::SLP_SRC);
        gclk_run = pb_run;
    end

    // All ticks share one counter, so a change at wrap is glitch free
    assign cpu_tick = tick(s_q.a_cpu, s_q.cnt);
    assign cpu_ce = cpu_tick && cpu_run;
    assign hsb_ce = cpu_tick && hsb_run;
    assign cpu_clk_en = {32{cpu_ce}} & s_q.cpu_mask;
    assign hsb_clk_en = {32{hsb_ce}} & s_q.hsb_mask;

    // One mask per domain and per bus
    generate
        for (genvar g = 0; g < scg_pkg::NPB; g++)
        begin : g_pb
            assign pb_ce[g] = tick(s_q.a_pb[g], s_q.cnt) && pb_run;
            assign pb_clk_en[g] = {32{pb_ce[g]}} & s_q.pb_mask[g];
        end
    endgenerate

    // Own bus clock lives in mask bit of first peripheral bus
    assign pm_ok = s_q.pb_mask[0][scg_pkg::PM_MASK_BIT];
    assign main_clock_source_field = s_q.src;
    assign irq = s_q.interrupt_status_register && s_q.interrupt_mask_register;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;
    // Reads take one wait state so data comes from a flop
    assign hreadyout = !(s_q.ap_act && !s_q.ap_wr && !s_q.rd_wait);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [7:0] a;
        logic wr;
        a = s_q.ap_addr;
        wr = s_q.ap_act && s_q.ap_wr && pm_ok;
        s_d = s_q;
        s_d.cnt = s_q.cnt + 8'h01;
        // Apply pending divisions only at prescaler wrap
        if (!s_q.ready && s_q.cnt == scg_pkg::CNT_WRAP)
        begin
            s_d.a_cpu = s_q.cpu;
            for (int i = 0; i < scg_pkg::NPB; i++)
            begin
                s_d.pb[i] = fix(s_q.pb[i], s_q.cpu);
                s_d.a_pb[i] = fix(s_q.pb[i], s_q.cpu);
            end
            s_d.ready = 1'b1;
        end
        // Bus data phase
        if (s_q.ap_act && !s_q.ap_wr && !s_q.rd_wait)
        begin
            s_d.rdata = pm_ok ? rd(s_q, a) : 32'h00000000;
            s_d.rd_wait = 1'b1;
        end
        else if (s_q.ap_act)
        begin
            s_d.ap_act = 1'b0;
            s_d.rd_wait = 1'b0;
        end
        if (wr)
        begin
            if (a == scg_pkg::OFS_MAIN)
                s_d.src = hwdata[2:0];
            if (a == scg_pkg::OFS_CPU_CLOCK_SELECT)
            begin
                s_d.cpu = {hwdata[scg_pkg::DIV_BIT], hwdata[2:0]};
                s_d.ready = 1'b0;
            end
            for (int i = 0; i < scg_pkg::NPB; i++)
            begin
                if (a == scg_pkg::OFS_PBSEL0 + 8'(4 * i))
                begin
                    s_d.pb[i] = {hwdata[scg_pkg::DIV_BIT], hwdata[2:0]};
                    s_d.ready = 1'b0;
                end
                if (a == scg_pkg::OFS_PBMASK0 + 8'(4 * i))
                    s_d.pb_mask[i] = hwdata;
            end
            if (a == scg_pkg::OFS_CPU_CLOCK_MASK)
                s_d.cpu_mask = hwdata;
            if (a == scg_pkg::OFS_HIGH_SPEED_BUS_CLOCK_MASK)
                s_d.hsb_mask = hwdata;
            if (a == scg_pkg::OFS_IER && hwdata[0])
                s_d.interrupt_mask_register = 1'b1;
            if (a == scg_pkg::OFS_IDR && hwdata[0])
                s_d.interrupt_mask_register = 1'b0;
            if (a == scg_pkg::OFS_ICR && hwdata[0])
                s_d.interrupt_status_register = 1'b0;
        end
        // Set beats a same-cycle clear
        if (s_d.ready && !s_q.ready)
            s_d.interrupt_status_register = 1'b1;
        // New address phase
        if (hsel && htrans[1] && hready)
        begin
            s_d.ap_act = 1'b1;
            s_d.ap_wr = hwrite;
            s_d.ap_addr = {haddr[7:2], 2'b00};
            s_d.rd_wait = 1'b0;
        end
        // Sleep entry and interrupt wake
        if (s_q.sleeping && wake_irq)
            s_d.sleeping = 1'b0;
        else if (!s_q.sleeping && sleep_req && sleep_idx <= scg_pkg::SLP_MAX)
        begin
            s_d.sleeping = 1'b1;
            s_d.slp_idx = sleep_idx;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Reset: RC source, undivided, all clocks on
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_q <= '0;
            s_q.src <= scg_pkg::SRC_SYSTEM_RC_OSCILLATOR;
            s_q.ready <= 1'b1;
            s_q.cpu_mask <= scg_pkg::MASK_RST;
            s_q.hsb_mask <= scg_pkg::MASK_RST;
            s_q.pb_mask <= {scg_pkg::NPB{scg_pkg::MASK_RST}};
        end
        else
            s_q <= s_d;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Bus, division and settle behaviour
    a_hsb_same_div: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !s_q.sleeping |-> hsb_ce == cpu_ce)
        else $error("bus clock differs from cpu clock");
    a_sel_ignored: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (s_q.ap_act && s_q.ap_wr && s_q.ap_addr == scg_pkg::OFS_HIGH_SPEED_BUS_CLOCK_SELECT)
        |=> $stable(s_q.cpu))
        else $error("bus select write changed division");
    a_ready_drops: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (s_q.ap_act && s_q.ap_wr && pm_ok &&
         s_q.ap_addr == scg_pkg::OFS_CPU_CLOCK_SELECT) |=> !s_q.ready)
        else $error("settled bit stayed high after write");
    a_ready_returns: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $fell(s_q.ready) |-> ##[1:256] s_q.ready)
        else $error("settled bit never returned");
    a_isr_on_rise: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(s_q.ready) |-> s_q.interrupt_status_register)
        else $error("status not set on settle");
    a_isr_clear: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (s_q.ap_act && s_q.ap_wr && pm_ok && hwdata[0] &&
         s_q.ap_addr == scg_pkg::OFS_ICR &&
         !(!s_q.ready && s_q.cnt == scg_pkg::CNT_WRAP)) |=> !irq)
        else $error("interrupt stayed after clear");
    a_pb_slower: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_q.ready |-> expo(s_q.a_pb[0]) >= expo(s_q.a_cpu))
        else $error("peripheral clock faster than cpu");

    // Sleep and own clock
    a_sleep_halts: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_q.sleeping |-> !cpu_ce && cpu_clk_en == 32'h00000000)
        else $error("cpu clocked during sleep");
    a_wake_irq: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_q.sleeping && wake_irq |=> !s_q.sleeping && cpu_run)
        else $error("interrupt did not wake");
    a_pm_locked: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !pm_ok |=> !pm_ok)
        else $error("own clock re-enabled without reset");

    // Source, lock and select; the lock must also freeze every mask
    a_src_hold: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !(s_q.ap_act && s_q.ap_wr && s_q.ap_addr == scg_pkg::OFS_MAIN)
        |=> $stable(s_q.src))
        else $error("source changed without a write");
    a_src_written: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (s_q.ap_act && s_q.ap_wr && pm_ok &&
         s_q.ap_addr == scg_pkg::OFS_MAIN)
        |=> {29'h0, s_q.src} == ($past(hwdata) & 32'h00000007))
        else $error("source write not applied");
    a_undiv_runs: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (!s_q.sleeping && !s_q.a_cpu.div) |-> cpu_ce)
        else $error("undivided cpu clock missed a cycle");
    a_pb1_slower: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_q.ready |-> expo(s_q.a_pb[1]) >= expo(s_q.a_cpu))
        else $error("second peripheral clock faster than cpu");
    a_ier_sets: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (s_q.ap_act && s_q.ap_wr && pm_ok && hwdata[0] &&
         s_q.ap_addr == scg_pkg::OFS_IER) |=> s_q.interrupt_mask_register)
        else $error("enable write did not set mask");
    a_mask_locked: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !pm_ok |=> $stable(s_q.cpu_mask) && $stable(s_q.hsb_mask) &&
            $stable(s_q.pb_mask))
        else $error("mask changed while own clock is off");
    a_locked_reads: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (!pm_ok && s_q.ap_act && !s_q.ap_wr && !s_q.rd_wait)
        |=> s_q.rdata == 32'h00000000)
        else $error("register readable while own clock is off");
    a_settle_wrap: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(s_q.ready) |-> $past(s_q.cnt) == scg_pkg::CNT_WRAP)
        else $error("division applied away from prescaler wrap");

    // Sleep index decoding
    a_sleep_enter: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (!s_q.sleeping && sleep_req && sleep_idx <= scg_pkg::SLP_MAX)
        |=> s_q.sleeping)
        else $error("sleep request not taken");
    a_bad_index: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (!s_q.sleeping && sleep_req && sleep_idx > scg_pkg::SLP_MAX)
        |=> !s_q.sleeping)
        else $error("illegal sleep index taken");
    a_hsb_stops: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (s_q.sleeping && s_q.slp_idx >= scg_pkg::SLP_HSB)
        |-> !hsb_ce && hsb_clk_en == 32'h00000000)
        else $error("bus clocked in deep sleep");
    a_pb_stops: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (s_q.sleeping && s_q.slp_idx >= scg_pkg::SLP_PB) |-> pb_ce == '0)
        else $error("peripheral clocked in standby");
    a_src_stops: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (s_q.sleeping && s_q.slp_idx >= scg_pkg::SLP_SRC) |-> !src_run)
        else $error("sources kept in stop");
    a_awake_runs: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !s_q.sleeping |-> hsb_run && pb_run && gclk_run && src_run)
        else $error("domain stopped while awake");

endmodule : scg_clock_gen

// *** bench/scg_periph_model.sv ***
`timescale 1ns/1ps
// Clocked modules on the far side; each counts the enables it receives
module scg_periph_model
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clr,
    input wire logic [7:0] ce,
    output logic [7:0][7:0] cnt
);
    // ------------------------------------------------------------
    // Enable pulse counters
    // ------------------------------------------------------------
    // A module with no enable does no work, so its count stays still
    always_ff @(posedge hclk or negedge hresetn)
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (!hresetn)
                cnt[i] <= 8'h00;
            else if (clr)
                cnt[i] <= 8'h00;
            else if (ce[i])
                cnt[i] <= cnt[i] + 8'h01;
        end
    end
endmodule : scg_periph_model

// *** bench/scg_clock_gen_test.sv ***
`timescale 1ns/1ps
module scg_clock_gen_test;
    typedef struct {string nm; logic [31:0] v;} scg_note_s;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, clr;
    logic sleep_req, wake_irq, cpu_ce, hsb_ce, gclk_run, src_run, irq;
    logic [31:0] haddr, hwdata, hrdata, seen_v, rd, v, cpu_en, hsb_en;
    logic [1:0] htrans, pb_ce;
    logic [2:0] hsize, sleep_idx, src;
    logic [1:0][31:0] pb_en;
    logic [7:0][7:0] cnt;
    scg_note_s q[$];
    event seen_ev;
    int err_total = 0;
    int compares = 0;
    int seed = 56;
    assign hready = hreadyout;

    scg_clock_gen uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .sleep_req(sleep_req),
        .sleep_idx(sleep_idx), .wake_irq(wake_irq),
        .main_clock_source_field(src), .cpu_ce(cpu_ce), .hsb_ce(hsb_ce),
        .pb_ce(pb_ce), .cpu_clk_en(cpu_en), .hsb_clk_en(hsb_en),
        .pb_clk_en(pb_en), .gclk_run(gclk_run), .src_run(src_run),
        .irq(irq));

    scg_periph_model periph (.hclk(hclk), .hresetn(hresetn), .clr(clr),
        .ce({pb_en[1][0], hsb_en[0], pb_ce[1], cpu_en[1], cpu_en[0],
            pb_ce[0], hsb_ce, cpu_ce}), .cnt(cnt));

    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // ------------------------------------------------------------
    // Scoreboard and bus tasks
    // ------------------------------------------------------------
    task test_done;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    task check(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    // Oldest note is matched against each result as it shows up
    initial
    begin
        scg_note_s n;
        forever
        begin
            @(seen_ev);
            n = q.pop_front();
            check(n.nm, seen_v, n.v);
        end
    end

    task note(input string nm, input logic [31:0] e, input logic [31:0] s);
        q.push_back('{nm, e});
        seen_v = s;
        ->seen_ev;
        #1;
    endtask : note

    // Bounded wait so a stuck slave ends the run instead of hanging it
    task wait_rdy;
        int n;
        @(posedge hclk);
        for (n = 0; hreadyout !== 1'b1; n++)
        begin
            if (n == 50)
            begin
                err_total++;
                test_done();
            end
            @(posedge hclk);
        end
    endtask : wait_rdy

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask : ahb

    task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h00000000);
        note(nm, e, rd);
    endtask : rdc

    // Poll settled bit; new selects are only written once it is high
    task settle;
        int n;
        for (n = 0; n < 300; n++)
        begin
            ahb(1'b0, scg_pkg::OFS_SR, 32'h00000000);
            if (rd[0] === 1'b1)
                break;
        end
        if (n == 300)
        begin
            err_total++;
            test_done();
        end
    endtask : settle

    task window(input int n);
        @(posedge hclk);
        clr <= 1'b1;
        @(posedge hclk);
        clr <= 1'b0;
        repeat (n) @(posedge hclk);
        #1;
    endtask : window

    task do_reset;
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
    endtask : do_reset

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {hresetn, hsel, hwrite, clr, sleep_req, wake_irq} = 6'h00;
        {haddr, hwdata, htrans, hsize, sleep_idx} = '0;
        hsize = 3'h2;
        do_reset();
        rdc("main", scg_pkg::OFS_MAIN, 32'h00000000);
        rdc("cpu_clock_mask", scg_pkg::OFS_CPU_CLOCK_MASK, 32'hFFFFFFFF);
        window(16);
        note("cpu undiv", 32'h10, cnt[0]);
        note("pb undiv", 32'h10, cnt[2]);
        note("pb1 undiv", 32'h10, cnt[5]);
        ahb(1'b1, scg_pkg::OFS_MAIN, 32'h00000003); // Taken as ready
        @(posedge hclk);
        #1;
        note("src", 32'h3, src);
        $display("reset and source test done");
        ahb(1'b1, scg_pkg::OFS_ICR, 32'h00000001);
        rdc("isr clr", scg_pkg::OFS_ISR, 32'h00000000);
        ahb(1'b1, scg_pkg::OFS_CPU_CLOCK_SELECT, 32'h00000081);
        settle();
        rdc("isr set", scg_pkg::OFS_ISR, 32'h00000001);
        window(16);
        note("cpu div4", 32'h04, cnt[0]);
        note("hsb div4", 32'h04, cnt[1]);
        note("pb adj", 32'h04, cnt[2]);
        note("pb1 adj", 32'h04, cnt[5]);
        note("pb1 mod0", 32'h04, cnt[7]);
        ahb(1'b1, scg_pkg::OFS_PBSEL0, 32'h00000083); // Slower than cpu
        settle();
        window(32);
        note("pb div16", 32'h02, cnt[2]);
        ahb(1'b1, scg_pkg::OFS_PBSEL0, 32'h00000000);
        settle();
        rdc("peripheral_division_field adj", scg_pkg::OFS_PBSEL0, 32'h00000081);
        for (int i = 0; i < 3; i++)
        begin
            v = $random(seed);
            ahb(1'b1, scg_pkg::OFS_HIGH_SPEED_BUS_CLOCK_SELECT, v);
            rdc("high_speed_bus_clock_select", scg_pkg::OFS_HIGH_SPEED_BUS_CLOCK_SELECT, 32'h00000081);
            ahb(1'b1, scg_pkg::OFS_HIGH_SPEED_BUS_CLOCK_MASK, v);
            rdc("high_speed_bus_clock_mask", scg_pkg::OFS_HIGH_SPEED_BUS_CLOCK_MASK, v);
        end
        rdc("unmapped", 8'h3C, 32'h00000000);
        $display("divide test done");
        ahb(1'b1, scg_pkg::OFS_IER, 32'h00000001);
        rdc("imr", scg_pkg::OFS_IMR, 32'h00000001);
        note("irq on", 32'h1, irq);
        ahb(1'b1, scg_pkg::OFS_ICR, 32'h00000001);
        @(posedge hclk);
        #1;
        note("irq off", 32'h0, irq);
        // Module 1 stands in for flash and stays clocked
        ahb(1'b1, scg_pkg::OFS_CPU_CLOCK_MASK, 32'hFFFFFFFE);
        window(16);
        note("mod0 gated", 32'h00, cnt[3]);
        note("mod1 runs", 32'h04, cnt[4]);
        note("hsb mod0", v[0] ? 32'h04 : 32'h00, cnt[6]);
        ahb(1'b1, scg_pkg::OFS_CPU_CLOCK_MASK, 32'hFFFFFFFF);
        window(16);
        note("mod0 back", 32'h04, cnt[3]);
        $display("irq and mask test done");
        for (int i = 0; i < 6; i++)
        begin
            @(posedge hclk);
            sleep_req <= 1'b1;
            sleep_idx <= 3'(i);
            @(posedge hclk);
            sleep_req <= 1'b0;
            window(16);
            note("cpu sleep", 32'h00, cnt[0]);
            note("hsb sleep", (i >= 1) ? 32'h0 : 32'h4, cnt[1]);
            note("pb sleep", (i >= 2) ? 32'h0 : 32'h4, cnt[2]);
            note("gclk", (i < 2) ? 32'h1 : 32'h0, gclk_run);
            note("src run", (i < 3) ? 32'h1 : 32'h0, src_run);
            @(posedge hclk);
            wake_irq <= 1'b1;
            @(posedge hclk);
            wake_irq <= 1'b0;
            window(16);
            note("cpu wake", 32'h04, cnt[0]);
        end
        // An index above the table must leave the cpu running
        @(posedge hclk);
        sleep_req <= 1'b1;
        sleep_idx <= 3'h7;
        @(posedge hclk);
        sleep_req <= 1'b0;
        window(16);
        note("bad idx", 32'h04, cnt[0]);
        $display("sleep test done");
        ahb(1'b1, scg_pkg::OFS_PBMASK0, 32'hFFFFFFFE);
        ahb(1'b1, scg_pkg::OFS_MAIN, 32'h00000005);
        @(posedge hclk);
        #1;
        note("src locked", 32'h3, src);
        rdc("locked rd", scg_pkg::OFS_MAIN, 32'h00000000);
        note("resp okay", 32'h0, hresp);
        do_reset();
        rdc("pbmask0", scg_pkg::OFS_PBMASK0, 32'hFFFFFFFF);
        note("src reset", 32'h0, src);
        $display("own clock test done");
        test_done();
    end
endmodule : scg_clock_gen_test
